// ===== config_port_gpio_watchdog_map.svh
// Offsets, keys, field positions, reset values and timing counts of the
// configuration port block. Definitions only; included by the watchdog timer and the top module.
`ifndef CONFIG_PORT_GPIO_WATCHDOG_MAP_SVH
`define CONFIG_PORT_GPIO_WATCHDOG_MAP_SVH

// ============================================================
// Host I/O ports and keys
`define CFG_INDEX_PORT      16'h002E
`define CFG_DATA_PORT       16'h002F
`define CFG_UNLOCK_KEY      8'h87
`define CFG_LOCK_KEY        8'hAA

// ============================================================
// Register indexes
`define IDX_FUNCTION_SELECT 8'h07
`define IDX_ACTIVATE        8'h30
`define IDX_IO_DIRECTION    8'hF0
`define IDX_IO_OUTPUT_VALUE 8'hF1
`define IDX_IO_INVERSION    8'hF2
`define IDX_WDT_UNIT_CTRL   8'hF5
`define IDX_WDT_COUNT       8'hF6

// ============================================================
// Logical function numbers and field positions
`define FUNC_WATCHDOG       8'h08
`define FUNC_GPIO           8'h09
`define ACTIVATE_BIT        0
`define WDT_MINUTE_BIT      3

// ============================================================
// Reset values
`define RST_FUNCTION_SELECT 8'h00
`define RST_IO_DIRECTION    8'hFF
`define RST_ZERO_BYTE       8'h00
`define RDATA_UNMAPPED      8'hFF

// ============================================================
// Timing
`define CLK_PERIOD_NS       10
`define SECOND_NS           1000000000
`define SECONDS_PER_MINUTE  60
`define RESET_HOLD_NS       160
`define RESET_HOLD_CYCLES   (`RESET_HOLD_NS / `CLK_PERIOD_NS)

`endif

// ===== config_port_gpio_watchdog_pkg.sv
// Types shared by the configuration port block.
// Assumes the constants of config_port_gpio_watchdog_map.svh beside it.
`default_nettype none

package config_port_gpio_watchdog_pkg;

	// ============================================================
	// Configuration space lock sequence
	typedef enum logic [1:0] {
		CFG_LOCKED   = 2'b00,
		CFG_HALF_KEY = 2'b01,
		CFG_OPEN     = 2'b10
	} unlock_state_t;

endpackage

`default_nettype wire

// ===== gpio_line_sampler.sv
// Input path of the 8-bit I/O port: pin synchroniser and inversion.
// Assumes pins arrive asynchronously to clk.
`default_nettype none

module gpio_line_sampler (
	input  wire  logic       clk,
	input  wire  logic       reset_n,
	input  wire  logic [7:0] pin_in,
	input  wire  logic [7:0] invert,
	output logic       [7:0] line_value
);

	logic [7:0] sync_first;
	logic [7:0] sync_second;

	// ============================================================
	// Per-line synchroniser and inversion
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_line
			// First stage is read only by the second
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					sync_first[i]  <= 1'b0;
					sync_second[i] <= 1'b0;
				end else begin
					sync_first[i]  <= pin_in[i];
					sync_second[i] <= sync_first[i];
				end
			end
			// One flips the line, zero passes it
			assign line_value[i] = sync_second[i] ^ invert[i];
		end
	endgenerate

endmodule

`default_nettype wire

// ===== watchdog_timer.sv
// Watchdog counter with second and minute prescaler.
// Assumes a single clock; TICKS_PER_SECOND gives cycles per second.
`default_nettype none
`include "config_port_gpio_watchdog_map.svh"

module watchdog_timer #(
	parameter int unsigned TICKS_PER_SECOND = `SECOND_NS / `CLK_PERIOD_NS
) (
	input  wire  logic       clk,
	input  wire  logic       reset_n,
	input  wire  logic       enable,
	input  wire  logic       minutes,
	input  wire  logic       load,
	input  wire  logic [7:0] load_value,
	output logic       [7:0] count,
	output logic             expire
);

	logic [31:0] second_cnt;
	logic [5:0]  minute_cnt;
	logic        second_tick;
	logic        unit_tick;

	// ============================================================
	// Prescaler
	assign second_tick = (second_cnt == 32'(TICKS_PER_SECOND - 1));
	assign unit_tick   = second_tick &&
		(!minutes || minute_cnt == 6'(`SECONDS_PER_MINUTE - 1));

	// Reload restarts the unit so a service gives a full period
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			second_cnt <= 32'h0000_0000;
			minute_cnt <= 6'h00;
		end else if (load || !enable || count == 8'h00) begin
			second_cnt <= 32'h0000_0000;
			minute_cnt <= 6'h00;
		end else if (second_tick) begin
			second_cnt <= 32'h0000_0000;
			minute_cnt <= unit_tick ? 6'h00 : minute_cnt + 6'h01;
		end else begin
			second_cnt <= second_cnt + 32'h0000_0001;
		end
	end

	// ============================================================
	// Down counter; parks at zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count  <= 8'h00;
			expire <= 1'b0;
		end else begin
			expire <= 1'b0;
			if (load) begin
				count <= load_value;
			end else if (enable && unit_tick && count != 8'h00) begin
				count <= count - 8'h01;
				if (count == 8'h01) begin
					expire <= 1'b1;
				end
			end
		end
	end

endmodule

`default_nettype wire

// ===== config_port_gpio_watchdog.sv
// Configuration space of an on-board I/O controller: index/data port
// decode, lock sequence, 8-bit I/O port and watchdog.
// Assumes host byte I/O strobes are synchronous to clk, one cycle each.
//
// Behaviour
// - Two successive writes of 87 to index port 2E open configuration space.
// - Index 07 through data port 2F picks function: 09 I/O, 08 watchdog.
// - Writing 01 to index 30 activates the selected function.
// - Direction bit one makes the line input, zero makes it output.
// - Output lines drive the matching bit of the value register F1.
// - Inversion bit one flips an input line's value, zero passes it.
// - Watchdog expiry without service asserts system reset.
// - Count register F6 loads the timeout, 1 to 255 units.
// - Control F5 bit 3 selects minutes when one, seconds when zero.
`default_nettype none
`include "config_port_gpio_watchdog_map.svh"

module config_port_gpio_watchdog #(
	parameter int unsigned TICKS_PER_SECOND = `SECOND_NS / `CLK_PERIOD_NS
) (
	input  wire  logic        clk,
	input  wire  logic        reset_n,
	input  wire  logic [15:0] io_addr,
	input  wire  logic [7:0]  io_wdata,
	input  wire  logic        io_write,
	input  wire  logic        io_read,
	output logic        [7:0] io_rdata,
	input  wire  logic [7:0]  gpio_in,
	output logic        [7:0] gpio_out,
	output logic        [7:0] gpio_oe,
	output logic              system_reset
);

	// ============================================================
	// Declarations
	config_port_gpio_watchdog_pkg::unlock_state_t unlock_state;
	config_port_gpio_watchdog_pkg::unlock_state_t next_unlock_state;

	logic [7:0] cfg_index;
	logic [7:0] function_select;
	logic [7:0] gpio_activate;
	logic [7:0] wdt_activate;
	logic [7:0] io_direction;
	logic [7:0] io_output_value;
	logic [7:0] io_inversion;
	logic [7:0] watchdog_unit_control;

	logic       index_write;
	logic       data_write;
	logic       index_read;
	logic       data_read;
	logic       cfg_open;
	logic       reg_write;
	logic       gpio_selected;
	logic       wdt_selected;
	logic       gpio_active;
	logic       wdt_active;
	logic       wdt_load;

	logic [7:0] line_value;
	logic [7:0] wdt_count;
	logic       wdt_expire;
	logic [7:0] next_rdata;
	logic [7:0] port_value;

	logic [$clog2(`RESET_HOLD_CYCLES + 1) - 1:0] reset_hold;

	// ============================================================
	// Port decode
	assign index_write   = io_write && io_addr == `CFG_INDEX_PORT;
	assign data_write    = io_write && io_addr == `CFG_DATA_PORT;
	assign index_read    = io_read && io_addr == `CFG_INDEX_PORT;
	assign data_read     = io_read && io_addr == `CFG_DATA_PORT;
	assign cfg_open      = unlock_state == config_port_gpio_watchdog_pkg::CFG_OPEN;
	assign reg_write     = data_write && cfg_open;
	assign gpio_selected = function_select == `FUNC_GPIO;
	assign wdt_selected  = function_select == `FUNC_WATCHDOG;
	assign gpio_active   = gpio_activate[`ACTIVATE_BIT];
	assign wdt_active    = wdt_activate[`ACTIVATE_BIT];

	// ============================================================
	// Lock sequence
	// Any other port access between the two keys breaks the pair
	always_comb begin
		next_unlock_state = unlock_state;
		case (unlock_state)
			config_port_gpio_watchdog_pkg::CFG_LOCKED: begin
				if (index_write && io_wdata == `CFG_UNLOCK_KEY) begin
					next_unlock_state = config_port_gpio_watchdog_pkg::CFG_HALF_KEY;
				end
			end
			config_port_gpio_watchdog_pkg::CFG_HALF_KEY: begin
				if (index_write && io_wdata == `CFG_UNLOCK_KEY) begin
					next_unlock_state = config_port_gpio_watchdog_pkg::CFG_OPEN;
				end else if (io_write || io_read) begin
					next_unlock_state = config_port_gpio_watchdog_pkg::CFG_LOCKED;
				end
			end
			config_port_gpio_watchdog_pkg::CFG_OPEN: begin
				if (index_write && io_wdata == `CFG_LOCK_KEY) begin
					next_unlock_state = config_port_gpio_watchdog_pkg::CFG_LOCKED;
				end
			end
			default: begin
				next_unlock_state = config_port_gpio_watchdog_pkg::CFG_LOCKED;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			unlock_state <= config_port_gpio_watchdog_pkg::CFG_LOCKED;
		end else begin
			unlock_state <= next_unlock_state;
		end
	end

	// ============================================================
	// Index register
	// Only takes writes once open; the lock key itself is not stored
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_index <= `RST_ZERO_BYTE;
		end else if (index_write && cfg_open && io_wdata != `CFG_LOCK_KEY) begin
			cfg_index <= io_wdata;
		end
	end

	// ============================================================
	// Logical function select
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			function_select <= `RST_FUNCTION_SELECT;
		end else if (reg_write && cfg_index == `IDX_FUNCTION_SELECT) begin
			function_select <= io_wdata;
		end
	end

	// ============================================================
	// Activation, one register per function
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			gpio_activate <= `RST_ZERO_BYTE;
			wdt_activate  <= `RST_ZERO_BYTE;
		end else if (reg_write && cfg_index == `IDX_ACTIVATE) begin
			if (gpio_selected) begin
				gpio_activate <= io_wdata;
			end
			if (wdt_selected) begin
				wdt_activate <= io_wdata;
			end
		end
	end

	// ============================================================
	// I/O port configuration registers
	// Directions come up as inputs so no line fights the board at power-up
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			io_direction    <= `RST_IO_DIRECTION;
			io_output_value <= `RST_ZERO_BYTE;
			io_inversion    <= `RST_ZERO_BYTE;
		end else if (reg_write && gpio_selected) begin
			case (cfg_index)
				`IDX_IO_DIRECTION: begin
					io_direction <= io_wdata;
				end
				`IDX_IO_OUTPUT_VALUE: begin
					io_output_value <= io_wdata;
				end
				`IDX_IO_INVERSION: begin
					io_inversion <= io_wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// ============================================================
	// Pin drivers
	// Inactive port floats every line regardless of direction
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			gpio_out <= 8'h00;
			gpio_oe  <= 8'h00;
		end else if (gpio_active) begin
			gpio_out <= io_output_value & ~io_direction;
			gpio_oe  <= ~io_direction;
		end else begin
			gpio_out <= 8'h00;
			gpio_oe  <= 8'h00;
		end
	end

	// ============================================================
	// Input path
	gpio_line_sampler u_sampler (
		.clk        (clk),
		.reset_n    (reset_n),
		.pin_in     (gpio_in),
		.invert     (io_inversion),
		.line_value (line_value)
	);

	// Inputs show the pin, outputs read back their own value
	assign port_value = (line_value & io_direction) |
		(io_output_value & ~io_direction);

	// ============================================================
	// Watchdog unit control
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			watchdog_unit_control <= `RST_ZERO_BYTE;
		end else if (reg_write && wdt_selected && cfg_index == `IDX_WDT_UNIT_CTRL) begin
			watchdog_unit_control <= io_wdata;
		end
	end

	assign wdt_load = reg_write && wdt_selected && cfg_index == `IDX_WDT_COUNT;

	// ============================================================
	// Watchdog counter
	watchdog_timer #(
		.TICKS_PER_SECOND (TICKS_PER_SECOND)
	) u_watchdog (
		.clk        (clk),
		.reset_n    (reset_n),
		.enable     (wdt_active),
		.minutes    (watchdog_unit_control[`WDT_MINUTE_BIT]),
		.load       (wdt_load),
		.load_value (io_wdata),
		.count      (wdt_count),
		.expire     (wdt_expire)
	);

	// ============================================================
	// System reset stretcher
	// Held for a fixed width so slow reset receivers still see it
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reset_hold   <= '0;
			system_reset <= 1'b0;
		end else if (wdt_expire) begin
			reset_hold   <= ($bits(reset_hold))'(`RESET_HOLD_CYCLES - 1);
			system_reset <= 1'b1;
		end else if (reset_hold != '0) begin
			reset_hold   <= reset_hold - ($bits(reset_hold))'(1);
			system_reset <= 1'b1;
		end else begin
			system_reset <= 1'b0;
		end
	end

	// ============================================================
	// Read data
	// Locked space reads as an undriven bus
	always_comb begin
		next_rdata = `RDATA_UNMAPPED;
		if (index_read && cfg_open) begin
			next_rdata = cfg_index;
		end else if (data_read && cfg_open) begin
			if (cfg_index == `IDX_FUNCTION_SELECT) begin
				next_rdata = function_select;
			end else if (cfg_index == `IDX_ACTIVATE && gpio_selected) begin
				next_rdata = gpio_activate;
			end else if (cfg_index == `IDX_ACTIVATE && wdt_selected) begin
				next_rdata = wdt_activate;
			end else if (gpio_selected) begin
				case (cfg_index)
					`IDX_IO_DIRECTION:    next_rdata = io_direction;
					`IDX_IO_OUTPUT_VALUE: next_rdata = port_value;
					`IDX_IO_INVERSION:    next_rdata = io_inversion;
					default:              next_rdata = `RDATA_UNMAPPED;
				endcase
			end else if (wdt_selected) begin
				case (cfg_index)
					`IDX_WDT_UNIT_CTRL: next_rdata = watchdog_unit_control;
					`IDX_WDT_COUNT:     next_rdata = wdt_count;
					default:            next_rdata = `RDATA_UNMAPPED;
				endcase
			end
		end
	end

	// Read data holds until the next read
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			io_rdata <= `RDATA_UNMAPPED;
		end else if (io_read) begin
			io_rdata <= next_rdata;
		end
	end

endmodule

`default_nettype wire

// ===== config_port_gpio_watchdog_chk.sv
// Checker of the configuration port block: host port, pins and watchdog.
// Sees only the top module's ports; bound in at the foot of this file.
`default_nettype none

module config_port_gpio_watchdog_chk #(
	parameter int unsigned TICKS_PER_SECOND = 10
) (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic [15:0] io_addr,
	input wire logic [7:0]  io_wdata,
	input wire logic        io_write,
	input wire logic        io_read,
	input wire logic [7:0]  io_rdata,
	input wire logic [7:0]  gpio_in,
	input wire logic [7:0]  gpio_out,
	input wire logic [7:0]  gpio_oe,
	input wire logic        system_reset
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	// ============================================================
	// Lock tracker: a stray access between the two keys starts over
	logic [1:0]  keys;
	int unsigned since_reset;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			keys <= 2'h0;
		else if (io_write && io_addr == 16'h002E && io_wdata == 8'h87 && keys != 2'h2)
			keys <= keys + 2'h1;
		else if (io_write && io_addr == 16'h002E && io_wdata == 8'hAA)
			keys <= 2'h0;
		else if ((io_write || io_read) && keys != 2'h2)
			keys <= 2'h0;
	end

	// Age since reset, saturating; an expiry needs at least one unit
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			since_reset <= 0;
		else if (since_reset <= TICKS_PER_SECOND)
			since_reset <= since_reset + 1;
	end

	// ============================================================
	// Assertions
	chk_locked_reads: assert property (io_read && keys != 2'h2 |=> io_rdata == 8'hFF)
		else $error("read while locked did not return FF");
	chk_other_port: assert property (io_read && io_addr != 16'h002E && io_addr != 16'h002F
		|=> io_rdata == 8'hFF) else $error("unmapped port read did not return FF");
	chk_rdata_hold: assert property (!io_read |=> $stable(io_rdata))
		else $error("read data moved without a read");
	chk_oe_cause: assert property ($changed(gpio_oe)
		|-> $past(io_write) || $past(io_write, 2) || $past(io_write, 3))
		else $error("output enables moved without a write");
	chk_out_cause: assert property ($changed(gpio_out)
		|-> $past(io_write) || $past(io_write, 2) || $past(io_write, 3))
		else $error("pin values moved without a write");
	chk_reset_width: assert property ($rose(system_reset)
		|-> system_reset[*8] ##1 system_reset[*8] ##1 !system_reset)
		else $error("system reset pulse not 16 cycles");
	chk_reset_late: assert property ($rose(system_reset) |-> since_reset > TICKS_PER_SECOND)
		else $error("system reset before one time unit");
	chk_stays_stopped: assert property ($fell(system_reset) |-> !system_reset[*8])
		else $error("watchdog fired again without reload");

	// Main scenarios reached
	cover property ($rose(system_reset));
	cover property (io_read && keys == 2'h2);
	cover property ($changed(gpio_oe));
endmodule

bind config_port_gpio_watchdog config_port_gpio_watchdog_chk #(
	.TICKS_PER_SECOND(TICKS_PER_SECOND)
) config_port_gpio_watchdog_chk_inst (
	.clk(clk), .reset_n(reset_n), .io_addr(io_addr), .io_wdata(io_wdata),
	.io_write(io_write), .io_read(io_read), .io_rdata(io_rdata), .gpio_in(gpio_in),
	.gpio_out(gpio_out), .gpio_oe(gpio_oe), .system_reset(system_reset)
);

`default_nettype wire

// ===== config_port_gpio_watchdog_tb.sv
// Self-checking bench of the configuration port block.
// Assumes the checker is bound in; host strobes last one cycle each.
`default_nettype none

module config_port_gpio_watchdog_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// Short second keeps the minute case near 600 cycles
	localparam int unsigned TPS = 10;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [15:0] io_addr = 16'h0000;
	logic [7:0]  io_wdata = 8'h00;
	logic        io_write = 1'b0;
	logic        io_read = 1'b0;
	logic [7:0]  io_rdata;
	logic [7:0]  gpio_in = 8'h00;
	logic [7:0]  gpio_out;
	logic [7:0]  gpio_oe;
	logic        system_reset;
	int          err_total = 0;
	int          comparisons = 0;
	int          n;

	// ============================================================
	// Clock and design
	always #5 clk = ~clk;

	config_port_gpio_watchdog #(.TICKS_PER_SECOND(TPS)) config_port_gpio_watchdog_inst (
		.clk(clk), .reset_n(reset_n), .io_addr(io_addr), .io_wdata(io_wdata),
		.io_write(io_write), .io_read(io_read), .io_rdata(io_rdata), .gpio_in(gpio_in),
		.gpio_out(gpio_out), .gpio_oe(gpio_oe), .system_reset(system_reset)
	);

	// ============================================================
	// Shared tasks
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// One-cycle strobes; the bus idles a cycle after each
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		io_addr <= a;
		io_wdata <= d;
		io_write <= 1'b1;
		@(posedge clk);
		io_write <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		io_addr <= a;
		io_read <= 1'b1;
		@(posedge clk);
		io_read <= 1'b0;
		#1;
		d = io_rdata;
	endtask

	task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
		wr(16'h002E, idx);
		wr(16'h002F, d);
	endtask

	task automatic reg_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] d;
		wr(16'h002E, idx);
		rd(16'h002F, d);
		check(what, {8'h00, d}, {8'h00, exp});
	endtask

	// Bounded wait for the reset pulse; running out ends the run
	task automatic wait_reset(input int lim, output int cnt);
		cnt = 0;
		while (system_reset !== 1'b1) begin
			@(posedge clk);
			#1;
			cnt++;
			if (cnt > lim) begin
				err_total++;
				close_out();
			end
		end
	endtask

	task automatic quiet(input int cycles, input string what);
		int hits;
		hits = 0;
		repeat (cycles) begin
			@(posedge clk);
			#1;
			if (system_reset !== 1'b0)
				hits++;
		end
		check(what, 16'(hits), 16'h0000);
	endtask

	// ============================================================
	// Scenarios
	task automatic s_lock();
		logic [7:0] d;
		rd(16'h002F, d);
		check("locked read", {8'h00, d}, 16'h00FF);
		wr(16'h002E, 8'h87);
		rd(16'h002E, d);
		wr(16'h002E, 8'h87);
		reg_chk("broken keys", 8'h07, 8'hFF);
		wr(16'h002E, 8'h87);
		wr(16'h002E, 8'h87);
		reg_wr(8'h07, 8'h09);
		reg_chk("function select", 8'h07, 8'h09);
		rd(16'h002E, d);
		check("index readback", {8'h00, d}, 16'h0007);
		rd(16'h0080, d);
		check("unmapped port", {8'h00, d}, 16'h00FF);
		reg_wr(8'h07, 8'h0A);
		reg_chk("no function", 8'hF0, 8'hFF);
	endtask

	task automatic s_gpio();
		reg_wr(8'h07, 8'h09);
		@(posedge clk);
		gpio_in <= 8'h3C;
		reg_wr(8'hF0, 8'h0F);
		reg_wr(8'hF1, 8'hA5);
		reg_wr(8'h30, 8'h02);
		repeat (3) @(posedge clk);
		#1;
		check("inactive pins", {gpio_oe, gpio_out}, 16'h0000);
		reg_wr(8'h30, 8'h01);
		repeat (3) @(posedge clk);
		#1;
		check("directions", {8'h00, gpio_oe}, 16'h00F0);
		check("pin values", {8'h00, gpio_out & gpio_oe}, 16'h00A0);
		reg_chk("pins plain", 8'hF1, 8'hAC);
		reg_wr(8'hF2, 8'hFF);
		reg_chk("pins inverted", 8'hF1, 8'hA3);
		check("outputs plain", {8'h00, gpio_out & gpio_oe}, 16'h00A0);
		reg_chk("absent index", 8'hF6, 8'hFF);
	endtask

	task automatic s_wdt();
		reg_wr(8'h07, 8'h08);
		reg_wr(8'h30, 8'h01);
		reg_wr(8'hF5, 8'h00);
		reg_wr(8'hF6, 8'h05);
		wait_reset(80, n);
		check("second expiry", 16'(n >= 48 && n <= 56), 16'h0001);
		repeat (20) @(posedge clk);
		reg_chk("count stopped", 8'hF6, 8'h00);
		quiet(60, "no rearm");
		reg_wr(8'hF6, 8'h03);
		repeat (13) @(posedge clk);
		reg_chk("count drops", 8'hF6, 8'h02);
		reg_wr(8'hF6, 8'h00);
		quiet(60, "stopped by zero");
		reg_wr(8'hF5, 8'h08);
		reg_chk("unit minutes", 8'hF5, 8'h08);
		reg_wr(8'hF6, 8'h01);
		wait_reset(700, n);
		check("minute expiry", 16'(n >= 596 && n <= 606), 16'h0001);
		wr(16'h002E, 8'hAA);
		reg_chk("relocked", 8'hF6, 8'hFF);
	endtask

	// ============================================================
	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		s_lock();
		s_gpio();
		s_wdt();
		close_out();
	end
endmodule

`default_nettype wire
